// >>> bench/bcr_host_model.sv
`timescale 1ns/1ns
// Host side of the register port; strobes change on falling edges only
module bcr_host_model (
  input  wire logic       core_clk,
  input  wire logic       regRvalid,
  input  wire logic [7:0] regRdata,
  output logic            regWrite,
  output logic            regRead,
  output logic      [4:0] regAddr,
  output logic      [7:0] regWdata
);
  initial begin
    regWrite = 1'b0;
    regRead  = 1'b0;
    regAddr  = 5'h00;
    regWdata = 8'h00;
  end

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge core_clk);
    regWrite = 1'b1;
    regAddr  = a;
    regWdata = d;
    @(negedge core_clk);
    regWrite = 1'b0;
    regWdata = ~d; // Stale data never lingers
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic ok);
    @(negedge core_clk);
    regRead = 1'b1;
    regAddr = a;
    @(negedge core_clk);
    regRead = 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (regRvalid === 1'b1) ok = 1'b1;
      else @(negedge core_clk);
    end
    d = regRdata;
  endtask
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ns
`include "bcr_map.svh"
module tb;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        regWrite, regRead, regRvalid, maintenanceUnlockMode;
  logic [4:0]  regAddr;
  logic [7:0]  regWdata, regRdata, got;
  logic [7:0]  tempCode = 8'h00;
  logic [47:0] otpData = 48'h0;
  wire  [47:0] biasBus;
  logic        otpProgrammed = 1'b1;
  logic        ok;
  int          n_fail = 0, check_count = 0, seed = 43909, mode = 0, d;
  int          mdl [0:17];
  int          otpImg [1:6];

  always #50 core_clk = ~core_clk;

  bias_control_register_bank u_dut (.core_clk(core_clk), .rstn(rstn), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .regRvalid(regRvalid), .otpData(otpData), .otpProgrammed(otpProgrammed),
    .tempCode(tempCode), .driverRefLevel(biasBus[7:0]),
    .driverCarrierGateTrim(biasBus[15:8]), .driverPeakGateTrim(biasBus[23:16]),
    .finalRefLevel(biasBus[31:24]), .finalCarrierGateTrim(biasBus[39:32]),
    .finalPeakGateTrim(biasBus[47:40]), .maintenanceUnlockMode(maintenanceUnlockMode));

  bcr_host_model u_host (.core_clk(core_clk), .regRvalid(regRvalid), .regRdata(regRdata),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata));

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input int e, input string m);
    check_count++;
    if (g !== e[7:0]) begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e[7:0]);
    end
  endtask

  function automatic int fmask(input int i);
    return (i == 1 || i == 4) ? 8'h3F : 8'hFF;
  endfunction

  task automatic load_otp();
    for (int i = 1; i <= 6; i++)
      mdl[i] = otpProgrammed ? (otpImg[i] & fmask(i)) : ((i == 1 || i == 4) ? 8'h20 : 8'h80);
  endtask

  // Addresses 0 to 17 plus the bias outputs and mode flag
  task automatic chk_all();
    for (int a = 0; a <= 17; a++) begin
      u_host.rd(a[4:0], got, ok);
      if (!ok) begin
        n_fail++;
        $display("CHECK FAILED %0t no read answer", $time);
        print_verdict();
      end
      chk(got, mdl[a], "read");
    end
    for (int i = 1; i <= 6; i++) chk(biasBus[8*i-8 +: 8], mdl[i], "bias");
    chk({7'h00, maintenanceUnlockMode}, mode, "mode");
  endtask

  task automatic wr_all(); // Random bytes to all but control and unlock
    for (int a = 1; a <= 16; a++) begin
      d = $random(seed);
      u_host.wr(a[4:0], d[7:0]);
      if (a <= 6 && mode == 1) mdl[a] = d & fmask(a);
    end
    d = $random(seed); // Temperature moves after settings are written
    tempCode = d[7:0];
    mdl[15] = d & 8'hFF;
  endtask

  initial begin
    foreach (mdl[a]) mdl[a] = 0;
    mdl[0] = 8'h01;
    mdl[7] = 8'hC0;
    for (int i = 1; i <= 6; i++) begin
      otpImg[i] = $random(seed); // Unused bits set on purpose
      otpData[8*i-8 +: 8] = otpImg[i][7:0];
    end
    d = $random(seed);
    tempCode = d[7:0];
    mdl[15] = d & 8'hFF;
    repeat (5) @(negedge core_clk);
    rstn = 1'b1;
    repeat (2) @(negedge core_clk);
    load_otp();
    chk_all();
    wr_all();
    chk_all();
    u_host.wr(`BCR_ADDR_UNLOCK, `BCR_UNLOCK_CODE);
    mode = 1;
    wr_all();
    u_host.wr(`BCR_ADDR_SYSCTL, 8'h9F);
    chk_all();
    u_host.wr(`BCR_ADDR_SYSCTL, 8'h20);
    mdl[0] = 8'h21;
    repeat (3) @(negedge core_clk);
    load_otp();
    chk_all();
    u_host.wr(`BCR_ADDR_SYSCTL, 8'h00);
    mdl[0] = 8'h01;
    wr_all();
    u_host.wr(`BCR_ADDR_SYSCTL, 8'h40);
    mdl[0] = 8'h41;
    mode = 0;
    repeat (3) @(negedge core_clk);
    load_otp();
    chk_all();
    u_host.wr(`BCR_ADDR_SYSCTL, 8'h00);
    mdl[0] = 8'h01;
    u_host.wr(`BCR_ADDR_UNLOCK, `BCR_UNLOCK_CODE);
    u_host.wr(`BCR_ADDR_UNLOCK, 8'h3C);
    wr_all();
    chk_all();
    u_host.wr(`BCR_ADDR_UNLOCK, `BCR_UNLOCK_CODE);
    mode = 1;
    wr_all();
    otpProgrammed = 1'b0;
    rstn = 1'b0;
    repeat (2) @(negedge core_clk);
    rstn = 1'b1;
    mode = 0;
    repeat (2) @(negedge core_clk);
    load_otp();
    chk_all();
    print_verdict();
  end
endmodule

// >>> design/bcr_map.svh
`ifndef BCR_MAP_SVH
`define BCR_MAP_SVH
`define BCR_ADDR_SYSCTL     5'h00
`define BCR_ADDR_DRV_REF    5'h01
`define BCR_ADDR_DRV_CAR    5'h02
`define BCR_ADDR_DRV_PEAK   5'h03
`define BCR_ADDR_FIN_REF    5'h04
`define BCR_ADDR_FIN_CAR    5'h05
`define BCR_ADDR_FIN_PEAK   5'h06
`define BCR_ADDR_PART_ID    5'h07
`define BCR_ADDR_TEMP       5'h0F
`define BCR_ADDR_UNLOCK     5'h11
`define BCR_SOFT_RESET_BIT  6
`define BCR_RELOAD_BIT      5
`define BCR_REF_MASK        8'h3F
`define BCR_REF_DEFAULT     8'h20
`define BCR_TRIM_DEFAULT    8'h80
`define BCR_UNLOCK_CODE     8'hE3
`define BCR_TEMP_RESET      8'h00
`define BCR_SYSCTL_RESET    8'h00
`endif

// >>> design/bcr_otp_select.sv
`timescale 1ns/1ns
`include "bcr_map.svh"
// Chooses OTP contents or built-in defaults for the six bias settings
module bcr_otp_select (
  input  wire logic [47:0] otpData,
  input  wire logic        otpProgrammed,
  output logic      [47:0] loadData
);
  localparam logic [47:0] DEFAULTS = {`BCR_TRIM_DEFAULT, `BCR_TRIM_DEFAULT, `BCR_REF_DEFAULT,
                                      `BCR_TRIM_DEFAULT, `BCR_TRIM_DEFAULT, `BCR_REF_DEFAULT};
  localparam logic [47:0] MASKS = {8'hFF, 8'hFF, `BCR_REF_MASK, 8'hFF, 8'hFF, `BCR_REF_MASK};
  // Defaults only for a blank array, otherwise OTP wins
  assign loadData = (otpProgrammed ? otpData : DEFAULTS) & MASKS;
endmodule

// >>> design/bcr_pkg.sv
package bcr_pkg;
  typedef enum logic [2:0] {
    BCR_LOAD = 3'h1,
    BCR_RUN  = 3'h2,
    BCR_IDLE = 3'h4
  } bcr_state_type;
endpackage

// >>> design/bias_control_register_bank.sv
`timescale 1ns/1ns
`include "bcr_map.svh"
module bias_control_register_bank
  import bcr_pkg::*;
#(
  parameter logic [3:0] CHIP_REVISION = 4'h1, // Arbitrary value
  parameter logic [5:0] DRAIN_CODE    = 6'h30,
  parameter logic [1:0] DEVICE_VER    = 2'h0  // Arbitrary value
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [4:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  output logic      [7:0]  regRdata,
  output logic             regRvalid,
  input  wire logic [47:0] otpData,
  input  wire logic        otpProgrammed,
  input  wire logic [7:0]  tempCode,
  output logic      [7:0]  driverRefLevel,
  output logic      [7:0]  driverCarrierGateTrim,
  output logic      [7:0]  driverPeakGateTrim,
  output logic      [7:0]  finalRefLevel,
  output logic      [7:0]  finalCarrierGateTrim,
  output logic      [7:0]  finalPeakGateTrim,
  output logic             maintenanceUnlockMode
);
  logic [7:0]    bias_r [6];
  logic [7:0]    bias_nxt [6];
  logic [7:0]    sysCtl_r, sysCtl_nxt;
  logic          unlock_r, unlock_nxt;
  logic [7:0]    temp_r, temp_nxt;
  logic [7:0]    rdata_r, rdata_nxt;
  logic          rvalid_r, rvalid_nxt;
  logic [47:0]   loadData;
  bcr_state_type state_r, state_nxt;
  logic          softReset, reload;

  bcr_otp_select u_otp_select (
    .otpData       (otpData),
    .otpProgrammed (otpProgrammed),
    .loadData      (loadData)
  );

  function automatic logic [7:0] fieldMask(input int idx);
    return (idx == 0 || idx == 3) ? `BCR_REF_MASK : 8'hFF;
  endfunction

  function automatic logic isBias(input logic [4:0] a);
    return (a >= `BCR_ADDR_DRV_REF) && (a <= `BCR_ADDR_FIN_PEAK);
  endfunction

  // Write of a new request bit is what triggers; holding it does nothing new
  assign softReset = regWrite && regAddr == `BCR_ADDR_SYSCTL
                     && regWdata[`BCR_SOFT_RESET_BIT] && !sysCtl_r[`BCR_SOFT_RESET_BIT];
  assign reload    = regWrite && regAddr == `BCR_ADDR_SYSCTL
                     && regWdata[`BCR_RELOAD_BIT] && !sysCtl_r[`BCR_RELOAD_BIT];

  always_comb begin
    state_nxt  = state_r;
    sysCtl_nxt = sysCtl_r;
    unlock_nxt = unlock_r;
    temp_nxt   = tempCode;
    for (int i = 0; i < 6; i++) begin
      bias_nxt[i] = bias_r[i];
    end
    // Key honoured in the load cycle too, so no mode write is ever lost
    if (regWrite && regAddr == `BCR_ADDR_UNLOCK) begin
      unlock_nxt = (regWdata == `BCR_UNLOCK_CODE);
    end
    case (state_r)
      BCR_LOAD: begin
        for (int i = 0; i < 6; i++) begin
          bias_nxt[i] = loadData[8*i +: 8];
        end
        state_nxt = BCR_RUN;
      end
      BCR_RUN, BCR_IDLE: begin
        state_nxt = BCR_RUN;
        if (regWrite) begin
          if (regAddr == `BCR_ADDR_SYSCTL) begin
            // Only request bits are stored; revision bits are not state
            sysCtl_nxt = regWdata & 8'h60;
          end
          for (int i = 0; i < 6; i++) begin
            if (unlock_r && regAddr == 5'(i + 1)) begin
              bias_nxt[i] = regWdata & fieldMask(i);
            end
          end
        end
        if (reload) begin
          state_nxt = BCR_LOAD;
        end
        if (softReset) begin
          // Settings reloaded and mode locked; the written request bits are kept
          state_nxt  = BCR_LOAD;
          unlock_nxt = 1'b0;
          sysCtl_nxt = regWdata & 8'h60;
        end
      end
      default: state_nxt = BCR_LOAD;
    endcase
  end

  always_comb begin
    rdata_nxt  = 8'h00;
    rvalid_nxt = regRead;
    if (regRead) begin
      if (regAddr == `BCR_ADDR_SYSCTL) begin
        rdata_nxt = sysCtl_r | {4'h0, CHIP_REVISION};
      end else if (isBias(regAddr)) begin
        rdata_nxt = bias_r[3'(regAddr - 5'h01)];
      end else if (regAddr == `BCR_ADDR_PART_ID) begin
        rdata_nxt = {DRAIN_CODE, DEVICE_VER};
      end else if (regAddr == `BCR_ADDR_TEMP) begin
        rdata_nxt = temp_r;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_r  <= BCR_LOAD;
      sysCtl_r <= `BCR_SYSCTL_RESET;
      unlock_r <= 1'b0;
      temp_r   <= `BCR_TEMP_RESET;
      for (int i = 0; i < 6; i++) begin
        bias_r[i] <= 8'h00;
      end
    end else begin
      state_r  <= state_nxt;
      sysCtl_r <= sysCtl_nxt;
      unlock_r <= unlock_nxt;
      temp_r   <= temp_nxt;
      for (int i = 0; i < 6; i++) begin
        bias_r[i] <= bias_nxt[i];
      end
    end
  end

  // Read answer registered so the host samples a settled byte
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign regRdata              = rdata_r;
  assign regRvalid             = rvalid_r;
  assign driverRefLevel        = bias_r[0];
  assign driverCarrierGateTrim = bias_r[1];
  assign driverPeakGateTrim    = bias_r[2];
  assign finalRefLevel         = bias_r[3];
  assign finalCarrierGateTrim  = bias_r[4];
  assign finalPeakGateTrim     = bias_r[5];
  assign maintenanceUnlockMode = unlock_r;

  a_unlock_enter: assert property (@(posedge core_clk) disable iff (!rstn)
    regWrite && regAddr == `BCR_ADDR_UNLOCK && regWdata == `BCR_UNLOCK_CODE && !softReset
    |=> maintenanceUnlockMode)
    else $error("unlock code did not enter maintenance mode");

  a_unlock_leave: assert property (@(posedge core_clk) disable iff (!rstn)
    regWrite && regAddr == `BCR_ADDR_UNLOCK && regWdata != `BCR_UNLOCK_CODE
    |=> !maintenanceUnlockMode)
    else $error("other code did not leave maintenance mode");

  a_locked_ref: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == BCR_RUN && !maintenanceUnlockMode && !reload && !softReset
    |=> $stable(driverRefLevel) && $stable(finalRefLevel))
    else $error("reference level changed while locked");

  a_locked_trim: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == BCR_RUN && !maintenanceUnlockMode && !reload && !softReset
    |=> $stable(driverCarrierGateTrim) && $stable(driverPeakGateTrim)
        && $stable(finalCarrierGateTrim) && $stable(finalPeakGateTrim))
    else $error("gate trim changed while locked");

  sequence s_reload_req;
    reload && !softReset;
  endsequence
  sequence s_loaded;
    ##1 driverCarrierGateTrim == $past(loadData[15:8])
      && finalPeakGateTrim == $past(loadData[47:40]);
  endsequence
  a_reload_otp: assert property (@(posedge core_clk) disable iff (!rstn)
    s_reload_req |=> s_loaded)
    else $error("reload did not copy OTP contents");

  a_soft_reset: assert property (@(posedge core_clk) disable iff (!rstn)
    softReset |=> !maintenanceUnlockMode ##1 driverRefLevel == $past(loadData[7:0]))
    else $error("soft reset did not restore defaults");

  a_ref_unused: assert property (@(posedge core_clk) disable iff (!rstn)
    driverRefLevel[7:6] == 2'h0 && finalRefLevel[7:6] == 2'h0)
    else $error("reference level unused bits set");

  a_revision_ro: assert property (@(posedge core_clk) disable iff (!rstn)
    regRead && regAddr == `BCR_ADDR_SYSCTL |=> regRdata[3:0] == CHIP_REVISION)
    else $error("chip revision changed");

  a_ident_read: assert property (@(posedge core_clk) disable iff (!rstn)
    regRead && regAddr == `BCR_ADDR_PART_ID |=> regRdata == {DRAIN_CODE, DEVICE_VER})
    else $error("identifier readback wrong");

  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    regRead && regAddr > `BCR_ADDR_PART_ID && regAddr != `BCR_ADDR_TEMP
    |=> regRdata == 8'h00)
    else $error("reserved address read nonzero");

  a_reset_load: assert property (@(posedge core_clk)
    !rstn ##1 rstn |=> driverPeakGateTrim == $past(loadData[23:16]))
    else $error("OTP not loaded after reset");

  a_temp_read: assert property (@(posedge core_clk) disable iff (!rstn)
    regRead && regAddr == `BCR_ADDR_TEMP && $past(rstn) |=> regRdata == $past(tempCode, 2))
    else $error("temperature readback wrong");

  a_read_answer: assert property (@(posedge core_clk) disable iff (!rstn)
    regRead |=> regRvalid)
    else $error("read strobe got no answer");

  a_idle_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
    !regRead |=> !regRvalid && regRdata == 8'h00)
    else $error("read answer without a read");

  a_ctl_unused: assert property (@(posedge core_clk) disable iff (!rstn)
    regRead && regAddr == `BCR_ADDR_SYSCTL |=> !regRdata[7] && !regRdata[4])
    else $error("control unused bits read nonzero");

  a_final_unused: assert property (@(posedge core_clk) disable iff (!rstn)
    regRead && regAddr == `BCR_ADDR_FIN_REF |=> regRdata[7:6] == 2'h0)
    else $error("final reference unused bits read nonzero");

  a_load_step: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == BCR_LOAD |=> state_r == BCR_RUN)
    else $error("load state did not finish");

  // Mode moves only on a key write or a soft reset
  a_unlock_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    !(regWrite && regAddr == `BCR_ADDR_UNLOCK) && !softReset
    |=> $stable(maintenanceUnlockMode))
    else $error("maintenance mode changed without a key write");

  // Same checks for each of the six settings
  for (genvar g = 0; g < 6; g++) begin : g_bias_chk
    a_bias_locked: assert property (@(posedge core_clk) disable iff (!rstn)
      regWrite && regAddr == 5'(g + 1) && !unlock_r && state_r != BCR_LOAD
      |=> $stable(bias_r[g]))
      else $error("bias setting written while locked");

    a_bias_write: assert property (@(posedge core_clk) disable iff (!rstn)
      regWrite && regAddr == 5'(g + 1) && unlock_r && state_r != BCR_LOAD
      |=> bias_r[g] == ($past(regWdata) & fieldMask(g)))
      else $error("bias setting write not taken");

    a_bias_other: assert property (@(posedge core_clk) disable iff (!rstn)
      regWrite && regAddr != 5'(g + 1) && regAddr != `BCR_ADDR_SYSCTL
      && state_r != BCR_LOAD |=> $stable(bias_r[g]))
      else $error("bias setting changed by another address");

    a_bias_hold: assert property (@(posedge core_clk) disable iff (!rstn)
      !regWrite && state_r != BCR_LOAD |=> $stable(bias_r[g]))
      else $error("bias setting changed without a write");

    a_bias_read: assert property (@(posedge core_clk) disable iff (!rstn)
      regRead && regAddr == 5'(g + 1) |=> regRdata == $past(bias_r[g]))
      else $error("bias setting readback wrong");

    a_bias_reload: assert property (@(posedge core_clk) disable iff (!rstn)
      reload |=> ##1 bias_r[g] == $past(loadData[8*g +: 8]))
      else $error("bias setting not reloaded");

    a_bias_soft: assert property (@(posedge core_clk) disable iff (!rstn)
      softReset |=> ##1 bias_r[g] == $past(loadData[8*g +: 8]))
      else $error("bias setting not restored by soft reset");

    a_bias_reset: assert property (@(posedge core_clk)
      !rstn ##1 rstn |=> bias_r[g] == $past(loadData[8*g +: 8]))
      else $error("bias setting not loaded after reset");
  end
endmodule
